// ==== verilog/cso_control.sv ====
// Behaviour
// - Reference range bit: 0 low range internal thresholds, 1 high range reference plus DAC.
// - Current range codes 01, 10, 11 pick low, medium, high current.
// - Code 00 turns oscillator off in low range, noise detection in high range.
// - Noise detection drops current sourcing and sinking, comparators stay active.
// - In noise detection, pin noise toggles the comparator and so produces counts.
// - Unit A osc clocks aux timer A or gated timer 1; unit B likewise B or 3.
// - Aux timer so configured is clocked from the sensing oscillator only.
// - Gated timer source code 11 clocks it from its sensing oscillator.
// - Gated timer off when run is 0; gate enable 1 makes the gate qualify counts.
// - Unit enable switches the unit; when off no pin is connected.
// - Read-only direction flag: 1 sourcing, 0 sinking.
// - Aux clock source 0 ignores the osc select and counts the system clock over four.
// - Channel field connects sense input 0 to 15 while the unit is enabled.
//
// The APB slave port and the register addresses were decided locally.
module cso_control (
	input logic pclk,
	input logic presetn,
	input logic [cso_pkg::ADDR_W-1:0] paddr,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [cso_pkg::DATA_W-1:0] pwdata,
	output logic [cso_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input logic [1:0] osc_cmp,
	input logic [1:0] aux_ext_pin,
	input logic [1:0] gate_in,
	output logic [1:0][15:0] pad_connect,
	output logic [1:0] ref_high_range,
	output logic [1:0] osc_enable,
	output logic [1:0] current_drive_en,
	output logic [1:0] comparator_en,
	output logic [1:0] noise_mode,
	output logic [1:0][1:0] current_level,
	output logic [1:0] osc_direction_flag,
	output logic [1:0] aux_tick,
	output logic [1:0] gated_tick
);
	import cso_pkg::*;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] base,
			input logic [7:0] step, input int u);
		return a == (u == 1 ? base + step : base);
	endfunction

	// Software visible control state, index 0 is unit A / timer 1
	logic [1:0] sense_en, next_sense_en;
	logic [1:0] ref_sel, next_ref_sel;
	logic [1:0][1:0] rng, next_rng;
	logic [1:0] aux_from_osc, next_aux_from_osc;
	logic [1:0][3:0] chan, next_chan;
	logic [1:0] aux_clk_src, next_aux_clk_src;
	logic [1:0][1:0] gt_src, next_gt_src;
	logic [1:0] gt_run, next_gt_run;
	logic [1:0] gt_ge, next_gt_ge;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic wr_access, setup, mapped;

	assign pready = 1'b1;
	assign setup = psel && !penable;
	assign wr_access = psel && penable && pwrite;

	always_comb begin
		next_sense_en = sense_en;
		next_ref_sel = ref_sel;
		next_rng = rng;
		next_aux_from_osc = aux_from_osc;
		next_chan = chan;
		next_aux_clk_src = aux_clk_src;
		next_gt_src = gt_src;
		next_gt_run = gt_run;
		next_gt_ge = gt_ge;
		next_prdata = prdata;
		next_pslverr = pslverr;
		mapped = 1'b0;
		for (int u = 0; u < UNITS; u++) begin
			mapped = mapped || hit(paddr, OFS_SENSE_CTL0_A, SENSE_STRIDE, u)
				|| hit(paddr, OFS_SENSE_CTL1_A, SENSE_STRIDE, u)
				|| hit(paddr, OFS_AUX_CTL_A, TIMER_STRIDE, u)
				|| hit(paddr, OFS_GATED_CTL_1, TIMER_STRIDE, u);
		end
		// Read data and error are settled in setup so the access needs no wait
		if (setup) begin
			next_prdata = RESET_WORD;
			next_pslverr = !mapped;
			for (int u = 0; u < UNITS; u++) begin
				if (hit(paddr, OFS_SENSE_CTL0_A, SENSE_STRIDE, u)) begin
					next_prdata[BIT_SENSE_EN] = sense_en[u];
					next_prdata[BIT_REF_RANGE] = ref_sel[u];
					next_prdata[BIT_RANGE_HI:BIT_RANGE_LO] = rng[u];
					next_prdata[BIT_OSC_DIR] = osc_direction_flag[u];
					next_prdata[BIT_AUX_FROM_OSC] = aux_from_osc[u];
				end
				if (hit(paddr, OFS_SENSE_CTL1_A, SENSE_STRIDE, u)) begin
					next_prdata[BIT_CHAN_HI:0] = chan[u];
				end
				if (hit(paddr, OFS_AUX_CTL_A, TIMER_STRIDE, u)) begin
					next_prdata[BIT_AUX_CLK_SRC] = aux_clk_src[u];
				end
				if (hit(paddr, OFS_GATED_CTL_1, TIMER_STRIDE, u)) begin
					next_prdata[BIT_GT_SRC_HI:BIT_GT_SRC_LO] = gt_src[u];
					next_prdata[BIT_GT_GATE_EN] = gt_ge[u];
					next_prdata[BIT_GT_RUN] = gt_run[u];
				end
			end
		end
		if (wr_access) begin
			for (int u = 0; u < UNITS; u++) begin
				// Direction flag is read-only, its written bit is dropped
				if (hit(paddr, OFS_SENSE_CTL0_A, SENSE_STRIDE, u)) begin
					next_sense_en[u] = pwdata[BIT_SENSE_EN];
					next_ref_sel[u] = pwdata[BIT_REF_RANGE];
					next_rng[u] = pwdata[BIT_RANGE_HI:BIT_RANGE_LO];
					next_aux_from_osc[u] = pwdata[BIT_AUX_FROM_OSC];
				end
				if (hit(paddr, OFS_SENSE_CTL1_A, SENSE_STRIDE, u)) begin
					next_chan[u] = pwdata[BIT_CHAN_HI:0];
				end
				if (hit(paddr, OFS_AUX_CTL_A, TIMER_STRIDE, u)) begin
					next_aux_clk_src[u] = pwdata[BIT_AUX_CLK_SRC];
				end
				if (hit(paddr, OFS_GATED_CTL_1, TIMER_STRIDE, u)) begin
					next_gt_src[u] = pwdata[BIT_GT_SRC_HI:BIT_GT_SRC_LO];
					next_gt_ge[u] = pwdata[BIT_GT_GATE_EN];
					next_gt_run[u] = pwdata[BIT_GT_RUN];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sense_en <= '0;
			ref_sel <= '0;
			rng <= '0;
			aux_from_osc <= '0;
			chan <= '0;
			aux_clk_src <= '0;
			gt_src <= '0;
			gt_run <= '0;
			gt_ge <= '0;
			prdata <= RESET_WORD;
			pslverr <= 1'b0;
		end else begin
			sense_en <= next_sense_en;
			ref_sel <= next_ref_sel;
			rng <= next_rng;
			aux_from_osc <= next_aux_from_osc;
			chan <= next_chan;
			aux_clk_src <= next_aux_clk_src;
			gt_src <= next_gt_src;
			gt_run <= next_gt_run;
			gt_ge <= next_gt_ge;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// Synchronisers: stage 1 feeds only stage 2; edges come from stages 2 and 3
	logic [1:0] osc_s1, osc_s2, osc_s3, pin_s1, pin_s2, pin_s3;
	logic [1:0] div_cnt, next_div_cnt;
	logic instr_tick;
	logic [1:0] osc_active, osc_tick, pin_edge;
	logic [1:0][15:0] next_pad;
	logic [1:0] next_osc_en, next_drive, next_noise, next_aux_tick, next_gated_tick;
	logic [1:0][1:0] next_level;
	logic [1:0] gt_src_tick;

	assign instr_tick = div_cnt == INSTR_DIV_LAST;

	always_comb begin
		next_div_cnt = div_cnt + 2'h1;
		for (int u = 0; u < UNITS; u++) begin
			next_osc_en[u] = sense_en[u] && (ref_sel[u] || rng[u] != RNG_OFF_OR_NOISE);
			next_noise[u] = sense_en[u] && ref_sel[u] && rng[u] == RNG_OFF_OR_NOISE;
			next_drive[u] = next_osc_en[u] && !next_noise[u];
			next_level[u] = next_osc_en[u] ? rng[u] : 2'b00;
			next_pad[u] = sense_en[u] ? 16'h0001 << chan[u] : 16'h0000;
			osc_active[u] = sense_en[u] && (ref_sel[u] || rng[u] != RNG_OFF_OR_NOISE);
			// Noise mode keeps comparator edges flowing to the timers
			osc_tick[u] = osc_active[u] && osc_s2[u] && !osc_s3[u];
			pin_edge[u] = pin_s2[u] && !pin_s3[u];
			if (!aux_clk_src[u]) begin
				next_aux_tick[u] = instr_tick;
			end else if (aux_from_osc[u]) begin
				next_aux_tick[u] = osc_tick[u];
			end else begin
				next_aux_tick[u] = pin_edge[u];
			end
			case (gt_src[u])
				GT_SRC_SENSE_OSC: gt_src_tick[u] = osc_tick[u];
				GT_SRC_SYSCLK: gt_src_tick[u] = 1'b1;
				default: gt_src_tick[u] = instr_tick;
			endcase
			next_gated_tick[u] = gt_run[u] && (!gt_ge[u] || gate_in[u]) && gt_src_tick[u];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_s1 <= '0;
			osc_s2 <= '0;
			osc_s3 <= '0;
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_s3 <= '0;
			div_cnt <= '0;
			pad_connect <= '0;
			ref_high_range <= '0;
			osc_enable <= '0;
			current_drive_en <= '0;
			comparator_en <= '0;
			noise_mode <= '0;
			current_level <= '0;
			aux_tick <= '0;
			gated_tick <= '0;
		end else begin
			osc_s1 <= osc_cmp;
			osc_s2 <= osc_s1;
			osc_s3 <= osc_s2;
			pin_s1 <= aux_ext_pin;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			div_cnt <= next_div_cnt;
			pad_connect <= next_pad;
			ref_high_range <= ref_sel;
			osc_enable <= next_osc_en;
			current_drive_en <= next_drive;
			comparator_en <= next_osc_en;
			noise_mode <= next_noise;
			current_level <= next_level;
			aux_tick <= next_aux_tick;
			gated_tick <= next_gated_tick;
		end
	end

	assign osc_direction_flag = osc_s2;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	ref_range_a: assert property (##1 ref_high_range == $past(ref_sel)) else $error("ref range");
	drive_level_a: assert property (osc_active[0] |=> current_level[0] == $past(rng[0]))
		else $error("current level");
	osc_off_a: assert property (!ref_sel[0] && rng[0] == RNG_OFF_OR_NOISE
		|=> !osc_enable[0] && !comparator_en[0]) else $error("osc not off");
	noise_drive_a: assert property (sense_en[0] && ref_sel[0] && rng[0] == RNG_OFF_OR_NOISE
		|=> noise_mode[0] && !current_drive_en[0] && comparator_en[0]) else $error("noise mode");
	pad_off_a: assert property (!sense_en[1] |=> pad_connect[1] == 16'h0000) else $error("pad on");
	pad_chan_a: assert property (sense_en[0]
		|=> pad_connect[0] == 16'h0001 << $past(chan[0])) else $error("pad select");
	aux_instr_a: assert property (!aux_clk_src[0] |=> aux_tick[0] == $past(instr_tick))
		else $error("aux instr clock");
	aux_osc_a: assert property (aux_clk_src[0] && aux_from_osc[0] && osc_active[0]
		&& $rose(osc_s2[0]) |=> aux_tick[0]) else $error("aux osc tick");
	osc_latency_a: assert property (osc_active[0] && $rose(osc_cmp[0]) ##1 osc_cmp[0]
		##1 osc_cmp[0] && osc_active[0] && aux_clk_src[0] && aux_from_osc[0] |=> aux_tick[0])
		else $error("sync latency");
	gated_off_a: assert property (!gt_run[0] |=> !gated_tick[0]) else $error("gated off");
	gated_gate_a: assert property (gt_ge[1] && !gate_in[1] |=> !gated_tick[1]) else $error("gate");
	gated_osc_a: assert property (gt_run[1] && !gt_ge[1] && gt_src[1] == GT_SRC_SENSE_OSC
		|=> gated_tick[1] == $past(osc_tick[1])) else $error("gated osc");

	noise_tick_c: cover property (noise_mode[0] ##1 aux_tick[0] && aux_clk_src[0]);
	gated_osc_c: cover property (gt_src[1] == 2'b11 && gt_ge[1] ##1 gated_tick[1]);
	instr_c: cover property (!aux_clk_src[1] ##1 aux_tick[1] ##4 aux_tick[1]);
	err_c: cover property (psel && penable && pslverr);
endmodule

// ==== include/cso_pkg.sv ====
package cso_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int UNITS = 2;
	localparam int CHANNELS = 16;

	// Register offsets; unit B and the second timer sit one stride above
	localparam logic [7:0] OFS_SENSE_CTL0_A = 8'h00;
	localparam logic [7:0] OFS_SENSE_CTL1_A = 8'h04;
	localparam logic [7:0] SENSE_STRIDE = 8'h08;
	localparam logic [7:0] OFS_AUX_CTL_A = 8'h10;
	localparam logic [7:0] OFS_GATED_CTL_1 = 8'h18;
	localparam logic [7:0] TIMER_STRIDE = 8'h04;

	// sense_control_0 fields
	localparam int BIT_SENSE_EN = 7;
	localparam int BIT_REF_RANGE = 6;
	localparam int BIT_RANGE_HI = 3;
	localparam int BIT_RANGE_LO = 2;
	localparam int BIT_OSC_DIR = 1;
	localparam int BIT_AUX_FROM_OSC = 0;
	// sense_control_1 field
	localparam int BIT_CHAN_HI = 3;
	// aux_timer_control field
	localparam int BIT_AUX_CLK_SRC = 5;
	// gated_timer_control fields
	localparam int BIT_GT_SRC_HI = 7;
	localparam int BIT_GT_SRC_LO = 6;
	localparam int BIT_GT_GATE_EN = 1;
	localparam int BIT_GT_RUN = 0;

	localparam logic [1:0] RNG_OFF_OR_NOISE = 2'b00;
	localparam logic [1:0] GT_SRC_SYSCLK = 2'b01;
	localparam logic [1:0] GT_SRC_SENSE_OSC = 2'b11;

	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	// Instruction clock is the system clock divided by four
	localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

endpackage

// ==== test/cso_osc_model.sv ====
module cso_osc_model (
	input logic pclk,
	input logic presetn,
	input logic run,
	input logic [3:0] half,
	output logic osc_cmp,
	output int rises
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	// Comparator rests low when the pad is quiet; slow pads use a long half period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_cmp <= 1'b0;
			cnt <= 4'h0;
			rises <= 0;
		end else if (!run) begin
			osc_cmp <= 1'b0;
			cnt <= 4'h0;
		end else if (cnt == half - 4'h1) begin
			cnt <= 4'h0;
			osc_cmp <= !osc_cmp;
			if (!osc_cmp) rises <= rises + 1;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule

// ==== test/cso_control_bench.sv ====
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
	$display("[ERR] %0t got %0h exp %0h", $time, a, e); end end
module cso_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr;
	wire [1:0] osc_cmp;
	logic [1:0] osc_run = 2'h0, gate_in = 2'h0, aux_ext_pin = 2'h0, flag, d1, d2;
	logic [1:0][15:0] pad_connect;
	logic [1:0][1:0] current_level;
	logic [1:0] ref_high_range, osc_enable, current_drive_en, comparator_en, noise_mode;
	logic [1:0] aux_tick, gated_tick;
	logic [3:0] half [2] = '{4'h3, 4'h3};
	int rises [2];
	int tk [4] = '{0, 0, 0, 0};
	int num_errors = 0, comparisons = 0;
	cso_control i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .osc_cmp, .aux_ext_pin, .gate_in, .pad_connect, .ref_high_range,
		.osc_enable, .current_drive_en, .comparator_en, .noise_mode, .current_level,
		.osc_direction_flag(flag), .aux_tick, .gated_tick);
	cso_osc_model i_osc_a (.pclk, .presetn, .run(osc_run[0]), .half(half[0]),
		.osc_cmp(osc_cmp[0]), .rises(rises[0]));
	cso_osc_model i_osc_b (.pclk, .presetn, .run(osc_run[1]), .half(half[1]),
		.osc_cmp(osc_cmp[1]), .rises(rises[1]));
	initial begin
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		d1 <= osc_cmp;
		d2 <= d1;
		for (int i = 0; i < 2; i++) begin
			if (aux_tick[i] === 1'b1) tk[i]++;
			if (gated_tick[i] === 1'b1) tk[i + 2]++;
		end
	end
	task print_verdict();
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			num_errors++;
			print_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic e;
		xfer(1'b1, a, d, x, e);
	endtask
	// Time base is a bench cycle count, never the timer being judged
	task measure(input int u, input int k, input int cyc, output int got, output int exp);
		int t0, r0;
		// Let a tick launched under the previous setting land first
		repeat (4) @(posedge pclk);
		@(negedge pclk);
		t0 = tk[k];
		r0 = rises[u];
		@(posedge pclk);
		osc_run[u] <= 1'b1;
		repeat (cyc) @(posedge pclk);
		osc_run[u] <= 1'b0;
		repeat (8) @(posedge pclk);
		@(negedge pclk);
		got = tk[k] - t0;
		exp = rises[u] - r0;
	endtask
	task test_regs();
		logic [31:0] d;
		logic e;
		for (int i = 0; i < 8; i++) begin
			xfer(1'b0, 8'(i * 4), 32'h0, d, e);
			`CHK({e, d}, 33'h0)
		end
		wr(8'h20, 32'h0000_00ff);
		xfer(1'b0, 8'h20, 32'h0, d, e);
		`CHK({e, d}, {1'b1, 32'h0})
		$display("test regs done");
	endtask
	task test_modes();
		logic on, nz;
		for (int m = 0; m < 2; m++) begin
			for (int r = 0; r < 4; r++) begin
				wr(8'h08, {24'h0, 1'b1, m[0], 2'h0, r[1:0], 2'h0});
				repeat (2) @(posedge pclk);
				#1;
				on = !(m == 0 && r == 0);
				nz = m == 1 && r == 0;
				`CHK(ref_high_range[1], m[0])
				`CHK(current_level[1], on ? r[1:0] : 2'h0)
				`CHK(osc_enable[1], on)
				`CHK(noise_mode[1], nz)
				`CHK({comparator_en[1], current_drive_en[1]}, {on, on & !nz})
			end
		end
		wr(8'h08, 32'h0000_004c);
		repeat (2) @(posedge pclk);
		#1;
		`CHK({osc_enable[1], comparator_en[1]}, 2'h0)
		$display("test modes done");
	endtask
	task test_channels();
		logic [31:0] d;
		logic e;
		wr(8'h00, 32'h0000_0080);
		foreach (half[i]) half[i] <= 4'h3;
		for (int c = 0; c < 16; c += 5) begin
			wr(8'h04, 32'(c));
			xfer(1'b0, 8'h04, 32'h0, d, e);
			repeat (2) @(posedge pclk);
			#1;
			`CHK(d, 32'(c))
			`CHK(pad_connect[0], 16'h1 << c)
		end
		wr(8'h00, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		#1;
		`CHK(pad_connect[0], 16'h0)
		$display("test channels done");
	endtask
	task test_aux();
		int g, x, nom, ld;
		wr(8'h00, 32'h0000_00c1);
		wr(8'h10, 32'h0000_0020);
		measure(0, 0, 120, g, x);
		`CHK(g, x)
		nom = g;
		@(posedge pclk);
		half[0] <= 4'h5;
		measure(0, 0, 120, g, x);
		`CHK(g, x)
		ld = g;
		`CHK(ld < nom && (nom + ld) / 2 > ld, 1'b1)
		wr(8'h00, 32'h0000_0081);
		measure(0, 0, 60, g, x);
		`CHK(g, 0)
		wr(8'h10, 32'h0000_0000);
		measure(0, 0, 31, g, x);
		`CHK(g, 10)
		$display("test aux done");
	endtask
	task test_gated();
		int g, x, a0;
		wr(8'h08, 32'h0000_00c4);
		wr(8'h14, 32'h0000_0020);
		wr(8'h1c, 32'h0000_00c0);
		// Taken after a late divider tick from the old aux B setting has landed
		a0 = tk[1];
		measure(1, 3, 60, g, x);
		`CHK(g, 0)
		wr(8'h1c, 32'h0000_00c1);
		measure(1, 3, 60, g, x);
		`CHK(g, x)
		wr(8'h1c, 32'h0000_00c3);
		measure(1, 3, 60, g, x);
		`CHK(g, 0)
		// Bench opens the gate for the window, as an overflow-toggled gate would
		@(posedge pclk);
		gate_in <= 2'h2;
		measure(1, 3, 60, g, x);
		`CHK(g, x)
		`CHK(tk[1], a0)
		// Aux B is on its pin: one rising edge is one count
		@(posedge pclk);
		aux_ext_pin <= 2'h2;
		repeat (4) @(posedge pclk);
		aux_ext_pin <= 2'h0;
		repeat (4) @(posedge pclk);
		#1;
		`CHK(tk[1], a0 + 1)
		// Other clock sources: every pclk, then pclk over four, in a 40-edge window
		wr(8'h1c, 32'h0000_0041);
		measure(1, 3, 31, g, x);
		`CHK(g, 40)
		wr(8'h1c, 32'h0000_0001);
		measure(1, 3, 31, g, x);
		`CHK(g, 10)
		$display("test gated done");
	endtask
	task test_direction();
		logic [31:0] d;
		logic e;
		wr(8'h00, 32'h0000_00cc);
		osc_run[0] <= 1'b1;
		repeat (40) begin
			@(negedge pclk);
			`CHK(flag[0], d2[0])
		end
		osc_run[0] <= 1'b0;
		wr(8'h00, 32'h0000_00ce);
		xfer(1'b0, 8'h00, 32'h0, d, e);
		`CHK(d, 32'h0000_00cc)
		$display("test direction done");
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		test_regs();
		test_modes();
		test_channels();
		test_aux();
		test_gated();
		test_direction();
		print_verdict();
	end
endmodule
